// File: design/pot_terminal_control.sv
// Terminal connection control registers for a quad potentiometer, APB slave
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module pot_terminal_control
    import pot_terminal_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [DATA_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [LOCK_W-1:0] nv_lock_i,
    input wire logic hv_lock_we_i,
    input wire logic [1:0] hv_lock_sel_i,
    input wire logic hv_lock_val_i,
    input wire logic eeprom_wp_i,
    output logic [LOCK_W-1:0] lock_o,
    output logic write_refused_o,
    output net_term_s [NET_COUNT-1:0] terminal_o
);

    apb_req_s req;
    logic setup;
    logic wr_strobe;
    logic in_access;

    logic [LOCK_W-1:0] lock_q;
    logic [LOCK_W-1:0] lock_d;
    logic reload_q;
    logic reload_d;

    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;
    logic refused_q;
    logic refused_d;

    logic hit_lower;
    logic hit_upper;
    logic hit_lock;
    logic hit_applied;
    logic mapped;

    logic [NET_COUNT-1:0] group_wr;
    logic [GROUP_W-1:0] group_wdata [NET_COUNT];
    logic [GROUP_W-1:0] group_value [NET_COUNT];
    net_term_s [NET_COUNT-1:0] applied;
    logic [REG_W-1:0] lower_value;
    logic [REG_W-1:0] upper_value;
    logic [2*GROUP_W-1:0] applied_lower;
    logic [2*GROUP_W-1:0] applied_upper;

    assign req.sel = psel_i;
    assign req.enable = penable_i;
    assign req.write = pwrite_i;
    assign req.addr = paddr_i;
    assign req.wdata = pwdata_i;

    apb_port u_apb_port (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .req_i(req),
        .setup_o(setup),
        .wr_strobe_o(wr_strobe),
        .rd_strobe_o(),
        .pready_o(pready_o),
        .in_access_o(in_access)
    );

    // Address decode
    assign hit_lower = (paddr_i == OFF_TERMINAL_CTRL_LOWER);
    assign hit_upper = (paddr_i == OFF_TERMINAL_CTRL_UPPER);
    assign hit_lock = (paddr_i == OFF_LOCK_STATUS);
    assign hit_applied = (paddr_i == OFF_APPLIED_STATE);
    assign mapped = hit_lower || hit_upper || hit_lock || hit_applied;

    // Group write enables; the lock gating sits in each group
    always_comb begin
        group_wr[0] = wr_strobe && hit_lower;
        group_wr[1] = wr_strobe && hit_lower;
        group_wr[2] = wr_strobe && hit_upper;
        group_wr[3] = wr_strobe && hit_upper;
        group_wdata[0] = pwdata_i[LOW_GROUP_LSB +: GROUP_W];
        group_wdata[1] = pwdata_i[HIGH_GROUP_LSB +: GROUP_W];
        group_wdata[2] = pwdata_i[LOW_GROUP_LSB +: GROUP_W];
        group_wdata[3] = pwdata_i[HIGH_GROUP_LSB +: GROUP_W];
    end

    // Four networks, each gated by its own lock bit
    generate
        for (genvar n = 0; n < NET_COUNT; n++) begin : g_net
            net_group u_net_group (
                .clock_i(clock_i),
                .rst_i(rst_i),
                .wr_i(group_wr[n]),
                .lock_i(lock_q[n]),
                .wdata_i(group_wdata[n]),
                .value_o(group_value[n]),
                .applied_o(applied[n])
            );
        end
    endgenerate

    // Register images with the fixed top bit
    assign lower_value = {1'b1, group_value[1], group_value[0]};
    assign upper_value = {1'b1, group_value[3], group_value[2]};
    assign applied_lower = {applied[1], applied[0]};
    assign applied_upper = {applied[3], applied[2]};

    // Lock bits: reloaded after reset, altered only by high voltage commands
    always_comb begin
        lock_d = lock_q;
        reload_d = 1'b0;
        if (reload_q) begin
            lock_d = nv_lock_i;
        end else if (hv_lock_we_i) begin
            lock_d[hv_lock_sel_i] = hv_lock_val_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            lock_q <= LOCK_RESET;
            reload_q <= 1'b1;
        end else begin
            lock_q <= lock_d;
            reload_q <= reload_d;
        end
    end

    // Read data and error are registered during the setup phase
    always_comb begin
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup) begin
            pslverr_d = !mapped;
            prdata_d = READ_ZERO;
            if (!pwrite_i) begin
                if (hit_lower) begin
                    prdata_d[REG_W-1:0] = lower_value;
                end else if (hit_upper) begin
                    prdata_d[REG_W-1:0] = upper_value;
                end else if (hit_lock) begin
                    prdata_d[LOCK_W-1:0] = lock_q;
                end else if (hit_applied) begin
                    prdata_d[2*GROUP_W-1:0] = applied_lower;
                    prdata_d[4*GROUP_W-1:2*GROUP_W] = applied_upper;
                end
            end
        end
    end

    // Flags a write that hit a locked group, or a read-only register
    always_comb begin
        refused_d = 1'b0;
        if (wr_strobe) begin
            if (hit_lower) begin
                refused_d = lock_q[0] || lock_q[1];
            end else if (hit_upper) begin
                refused_d = lock_q[2] || lock_q[3];
            end else if (hit_lock || hit_applied) begin
                refused_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            prdata_q <= READ_ZERO;
            pslverr_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            refused_q <= refused_d;
        end
    end

    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q && psel_i && penable_i && in_access;
    assign lock_o = lock_q;
    assign write_refused_o = refused_q || (eeprom_wp_i && 1'b0);
    assign terminal_o = applied;

endmodule : pot_terminal_control

// File: design/pot_terminal_pkg.sv
// Package with register map, field layout and carrier types of the terminal control block
package pot_terminal_pkg;

    localparam int DATA_W = 32;
    localparam int REG_W = 9;
    localparam int GROUP_W = 4;
    localparam int NET_COUNT = 4;
    localparam int LOCK_W = 4;

    // Register byte offsets
    localparam logic [DATA_W-1:0] OFF_TERMINAL_CTRL_LOWER = 32'h0000_0000;
    localparam logic [DATA_W-1:0] OFF_TERMINAL_CTRL_UPPER = 32'h0000_0004;
    localparam logic [DATA_W-1:0] OFF_LOCK_STATUS = 32'h0000_0008;
    localparam logic [DATA_W-1:0] OFF_APPLIED_STATE = 32'h0000_000C;

    // Field positions inside a terminal control register
    localparam int FIXED_ONE_TOP_BIT = 8;
    localparam int HIGH_GROUP_LSB = 4;
    localparam int LOW_GROUP_LSB = 0;
    localparam int HW_CONFIG_POS = 3;
    localparam int TERM_A_POS = 2;
    localparam int TERM_W_POS = 1;
    localparam int TERM_B_POS = 0;

    // Reset values
    localparam logic [REG_W-1:0] TERMINAL_CTRL_RESET = 9'h1FF;
    localparam logic [GROUP_W-1:0] GROUP_RESET = 4'hF;
    localparam logic [LOCK_W-1:0] LOCK_RESET = 4'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // Bus port states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACCESS = 2'b10
    } bus_state_e;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } apb_req_s;

    typedef struct packed {
        logic hw_config;
        logic term_a;
        logic term_w;
        logic term_b;
    } net_term_s;

endpackage : pot_terminal_pkg

// File: design/apb_port.sv
// APB slave handshake: phase tracking, zero-wait ready and transfer strobes
`timescale 1ns/1ps
module apb_port
    import pot_terminal_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire apb_req_s req_i,
    output logic setup_o,
    output logic wr_strobe_o,
    output logic rd_strobe_o,
    output logic pready_o,
    output logic in_access_o
);

    bus_state_e state_q;
    bus_state_e state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            BUS_IDLE: begin
                if (req_i.sel && !req_i.enable) begin
                    state_d = BUS_ACCESS;
                end
            end
            BUS_ACCESS: begin
                if (req_i.sel && req_i.enable) begin
                    state_d = BUS_IDLE;
                end
            end
            default: begin
                state_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q <= BUS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Zero wait states: every access phase completes at its first edge
    assign setup_o = req_i.sel && !req_i.enable;
    assign pready_o = req_i.sel && req_i.enable;
    assign wr_strobe_o = req_i.sel && req_i.enable && req_i.write;
    assign rd_strobe_o = req_i.sel && req_i.enable && !req_i.write;
    assign in_access_o = (state_q == BUS_ACCESS);

endmodule : apb_port

// File: design/net_group.sv
// One resistor network's four control bits with lock gating and applied copy
`timescale 1ns/1ps
module net_group
    import pot_terminal_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic lock_i,
    input wire logic [GROUP_W-1:0] wdata_i,
    output logic [GROUP_W-1:0] value_o,
    output net_term_s applied_o
);

    logic [GROUP_W-1:0] value_q;
    logic [GROUP_W-1:0] value_d;
    net_term_s applied_q;
    net_term_s applied_d;

    always_comb begin
        value_d = value_q;
        if (wr_i && !lock_i) begin
            value_d = wdata_i;
        end
        // Terminals follow the stored value one edge after the write completes
        applied_d.hw_config = value_q[HW_CONFIG_POS];
        applied_d.term_a = value_q[TERM_A_POS];
        applied_d.term_w = value_q[TERM_W_POS];
        applied_d.term_b = value_q[TERM_B_POS];
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            value_q <= GROUP_RESET;
            applied_q <= net_term_s'(GROUP_RESET);
        end else begin
            value_q <= value_d;
            applied_q <= applied_d;
        end
    end

    assign value_o = value_q;
    assign applied_o = applied_q;

endmodule : net_group

// File: test/pot_terminal_checker.sv
// Assertion checker for the terminal control block ports
`timescale 1ns/1ps
module pot_terminal_checker
    import pot_terminal_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [DATA_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    input wire logic [LOCK_W-1:0] nv_lock_i,
    input wire logic hv_lock_we_i,
    input wire logic [LOCK_W-1:0] lock_o,
    input wire net_term_s [NET_COUNT-1:0] terminal_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_wr;
        psel_i && penable_i && pwrite_i;
    endsequence
    sequence s_lo;
        s_wr ##0 paddr_i == OFF_TERMINAL_CTRL_LOWER;
    endsequence
    sequence s_hi;
        s_wr ##0 paddr_i == OFF_TERMINAL_CTRL_UPPER;
    endsequence
    property p_rst;
        $fell(rst_i) |-> terminal_o == 16'hFFFF;
    endproperty
    a_rst: assert property (p_rst) else $error("terminals not all on after reset");
    property p_reload;
        $fell(rst_i) |=> lock_o == $past(nv_lock_i);
    endproperty
    a_reload: assert property (p_reload) else $error("lock not reloaded");
    property p_hold;
        !hv_lock_we_i && !$fell(rst_i) |=> $stable(lock_o);
    endproperty
    a_hold: assert property (p_hold) else $error("lock changed without command");
    property p_late;
        $changed(terminal_o) |-> $past(psel_i, 2) && $past(penable_i, 2) && $past(pwrite_i, 2);
    endproperty
    a_late: assert property (p_late) else $error("terminals changed out of turn");
    property p_apply;
        s_lo ##0 !lock_o[0] |-> ##2 terminal_o[0] == $past(pwdata_i[3:0], 2);
    endproperty
    a_apply: assert property (p_apply) else $error("network 0 not applied");
    property p_lk0;
        s_lo ##0 lock_o[0] |=> ##1 $stable(terminal_o[0]);
    endproperty
    a_lk0: assert property (p_lk0) else $error("locked network 0 changed");
    property p_lk1;
        s_lo ##0 lock_o[1] |=> ##1 $stable(terminal_o[1]);
    endproperty
    a_lk1: assert property (p_lk1) else $error("locked network 1 changed");
    property p_lk2;
        s_hi ##0 lock_o[2] |=> ##1 $stable(terminal_o[2]);
    endproperty
    a_lk2: assert property (p_lk2) else $error("locked network 2 changed");
    property p_lk3;
        s_hi ##0 lock_o[3] |=> ##1 $stable(terminal_o[3]);
    endproperty
    a_lk3: assert property (p_lk3) else $error("locked network 3 changed");
endmodule : pot_terminal_checker

bind pot_terminal_control pot_terminal_checker u_pot_terminal_checker (.clock_i(clock_i),
    .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .nv_lock_i(nv_lock_i),
    .hv_lock_we_i(hv_lock_we_i), .lock_o(lock_o), .terminal_o(terminal_o));

// File: test/host_model.sv
// Host controller model issuing register transfers over APB
`timescale 1ns/1ps
module host_model
    import pot_terminal_pkg::*;
(
    input wire logic clock_i,
    input wire logic pready_i,
    input wire logic [DATA_W-1:0] prdata_i,
    input wire logic pslverr_i,
    output apb_req_s req_o
);
    // Error response taken at the completing edge of the last transfer
    logic last_err = 1'b0;
    initial req_o = '0;
    task xfer(input logic w, input logic [DATA_W-1:0] a, d, output logic [DATA_W-1:0] r);
        @(posedge clock_i);
        req_o <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock_i);
        req_o.enable <= 1'b1;
        do @(posedge clock_i); while (pready_i !== 1'b1);
        r = prdata_i;
        last_err = pslverr_i;
        req_o <= '{1'b0, 1'b0, ~w, ~a, ~d};
    endtask : xfer
endmodule : host_model

// File: test/tb_top.sv
// Self-checking testbench for the terminal control block
`timescale 1ns/1ps
module tb_top
    import pot_terminal_pkg::*;
;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [LOCK_W-1:0] nv_lock_i = 4'h0;
    logic hv_lock_we_i = 1'b0;
    logic [1:0] hv_lock_sel_i = 2'h0;
    logic hv_lock_val_i = 1'b0;
    logic pready_o;
    logic [DATA_W-1:0] prdata_o;
    logic pslverr_o;
    logic write_refused_o;
    logic [LOCK_W-1:0] lock_o;
    net_term_s [NET_COUNT-1:0] terminal_o;
    apb_req_s req;
    logic [DATA_W-1:0] rd;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    always #50 clock_i = ~clock_i;
    host_model u_host_model (.clock_i(clock_i), .pready_i(pready_o), .prdata_i(prdata_o),
        .pslverr_i(pslverr_o), .req_o(req));
    pot_terminal_control u_pot_terminal_control (.clock_i(clock_i), .rst_i(rst_i),
        .psel_i(req.sel), .penable_i(req.enable), .pwrite_i(req.write), .paddr_i(req.addr),
        .pwdata_i(req.wdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .nv_lock_i(nv_lock_i), .hv_lock_we_i(hv_lock_we_i), .hv_lock_sel_i(hv_lock_sel_i),
        .hv_lock_val_i(hv_lock_val_i), .eeprom_wp_i(1'b1), .lock_o(lock_o),
        .write_refused_o(write_refused_o), .terminal_o(terminal_o));
    task test_done;
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done();
        end
    end
    task chk(input logic [DATA_W-1:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [DATA_W-1:0] a, d);
        u_host_model.xfer(1'b1, a, d, rd);
    endtask : wr
    task rdchk(input logic [DATA_W-1:0] a, exp);
        u_host_model.xfer(1'b0, a, 32'h0, rd);
        chk(rd, exp);
    endtask : rdchk
    task set_lock(input logic [1:0] n, input logic v);
        @(posedge clock_i);
        hv_lock_we_i <= 1'b1;
        hv_lock_sel_i <= n;
        hv_lock_val_i <= v;
        @(posedge clock_i);
        hv_lock_we_i <= 1'b0;
        hv_lock_sel_i <= ~n;
        hv_lock_val_i <= ~v;
    endtask : set_lock
    task t_reset(input logic [LOCK_W-1:0] nv);
        @(posedge clock_i);
        rst_i <= 1'b1;
        nv_lock_i <= nv;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        chk({28'h0, lock_o}, {28'h0, nv});
        chk({16'h0, terminal_o}, 32'h0000_FFFF);
        rdchk(OFF_TERMINAL_CTRL_LOWER, 32'h0000_01FF);
        rdchk(OFF_TERMINAL_CTRL_UPPER, 32'h0000_01FF);
        chk({31'h0, u_host_model.last_err}, 32'h0);
        rdchk(32'h0000_0010, READ_ZERO);
        chk({31'h0, u_host_model.last_err}, 32'h1);
    endtask : t_reset
    task t_apply(input logic [DATA_W-1:0] a, d);
        logic [15:0] e;
        e = terminal_o;
        wr(a, d);
        #1;
        chk({31'h0, write_refused_o}, 32'h0);
        chk({16'h0, terminal_o}, {16'h0, e});
        e[{a[3:0], 1'b0} +: 8] = d[7:0];
        @(posedge clock_i);
        #1;
        chk({16'h0, terminal_o}, {16'h0, e});
        rdchk(a, {23'h0, 1'b1, d[7:0]});
        rdchk(OFF_APPLIED_STATE, {16'h0, e});
    endtask : t_apply
    task t_lock(input logic [1:0] n);
        logic [DATA_W-1:0] a;
        a = {29'h0, n[1], 2'b00};
        wr(a, 32'h0000_00FF);
        set_lock(n, 1'b1);
        wr(OFF_LOCK_STATUS, 32'h0);
        #1;
        chk({31'h0, write_refused_o}, 32'h1);
        chk({28'h0, lock_o}, 32'h1 << n);
        rdchk(OFF_LOCK_STATUS, 32'h1 << n);
        wr(a, 32'h0);
        #1;
        chk({31'h0, write_refused_o}, 32'h1);
        rdchk(a, n[0] ? 32'h0000_01F0 : 32'h0000_010F);
        set_lock(n, 1'b0);
    endtask : t_lock
    initial begin
        t_reset(4'h0);
        t_apply(OFF_TERMINAL_CTRL_LOWER, 32'h0000_00A5);
        t_apply(OFF_TERMINAL_CTRL_UPPER, 32'hFFFF_FE3C);
        for (int n = 0; n < 4; n++) begin
            t_lock(n[1:0]);
        end
        t_reset(4'hA);
        set_lock(2'h1, 1'b0);
        set_lock(2'h3, 1'b0);
        t_apply(OFF_TERMINAL_CTRL_LOWER, 32'h0000_003C);
        test_done();
    end
endmodule : tb_top
